// ### shared/alu_defs.svh
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PTR0        8'h01
`define IDX_FLAGS       8'h04
`define IDX_PTR1        8'h09
`define IDX_WORK        8'h0a
`define IDX_PROD_LO     8'h18
`define IDX_PROD_HI     8'h19
`define IDX_OP_CMD      8'h20
`define IDX_FILE_OPND   8'h21
`define IDX_PTR_STEP    8'h22

// ----------------------------------------------------------------
// flags register fields
// ----------------------------------------------------------------
`define FLG_CARRY       0
`define FLG_SPILL       1
`define FLG_ZERO        2
`define FLG_RANGE       3
`define FLG_P0_LSB      4
`define FLG_P1_LSB      6
`define FLAGS_HI_RST    4'hf
`define FLAGS_LO_MASK   4'hf

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define CMD_OP_LSB      0
`define CMD_SRC_LSB     4
`define CMD_DST_LSB     6
`define CMD_IMM_LSB     8
`define CMD_BIT_LSB     8
`define CMD_BITSET      11

// ----------------------------------------------------------------
// pointer update modes
// ----------------------------------------------------------------
`define PTR_MODE_DEC    2'h0
`define PTR_MODE_INC    2'h1

`endif

// ### shared/alu_pkg.sv
package alu_pkg;

    typedef enum logic [3:0] {
        OP_ADD   = 4'h0,
        OP_ADDC  = 4'h1,
        OP_SUB   = 4'h2,
        OP_AND   = 4'h3,
        OP_OR    = 4'h4,
        OP_XOR   = 4'h5,
        OP_MOVE  = 4'h6,
        OP_CLEAR = 4'h7,
        OP_COMP  = 4'h8,
        OP_INC   = 4'h9,
        OP_DEC   = 4'ha,
        OP_RRC   = 4'hb,
        OP_RLC   = 4'hc,
        OP_SWAP  = 4'hd,
        OP_BIT   = 4'he,
        OP_MUL   = 4'hf
    } op_t;

    typedef enum logic [1:0] {
        SRC_WORK = 2'h0,
        SRC_FILE = 2'h1,
        SRC_IMM  = 2'h2
    } src_t;

    typedef enum logic [1:0] {
        DST_WORK  = 2'h0,
        DST_FILE  = 2'h1,
        DST_FLAGS = 2'h2,
        DST_NONE  = 2'h3
    } dst_t;

endpackage

// ### shared/alu_add_if.sv
`timescale 1ns/1ns
`default_nettype none

interface alu_add_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] sum;
    logic       cout;
    logic       half;
    logic       ovf;

    modport requester (input clk, input rst_n, output a, output b,
                       output cin, input sum, input cout, input half,
                       input ovf);
    modport adder     (input clk, input rst_n, input a, input b,
                       input cin, output sum, output cout, output half,
                       output ovf);
endinterface

`default_nettype wire

// ### rtl/alu_adder8.sv
`timescale 1ns/1ns
`default_nettype none

module alu_adder8 (
    alu_add_if.adder add
);
    logic [4:0] low_sum;
    logic [7:0] seven_sum;
    logic [8:0] full_sum;

    always_comb begin
        low_sum   = {1'b0, add.a[3:0]} + {1'b0, add.b[3:0]}
                  + {4'h0, add.cin};
        seven_sum = {1'b0, add.a[6:0]} + {1'b0, add.b[6:0]}
                  + {7'h00, add.cin};
        full_sum  = {1'b0, add.a} + {1'b0, add.b} + {8'h00, add.cin};
        add.sum   = full_sum[7:0];
        add.half  = low_sum[4];
        add.cout  = full_sum[8];
        // RULE_08: signed range error
        // sign changes wrongly when carries into and out of bit 7 differ
        add.ovf   = seven_sum[7] ^ full_sum[8];
    end

    // RULE_18: one adder, checked
    chk_adder_sum: assert property (@(posedge add.clk) // RULE_18 RULE_08
        disable iff (!add.rst_n)
        {add.cout, add.sum} == ({1'b0, add.a} + {1'b0, add.b}
                                + {8'h00, add.cin})
        && add.ovf == (add.a[7] == add.b[7] && add.sum[7] != add.a[7]))
        else $error("adder sum or carry wrong");

endmodule

`default_nettype wire

// ### rtl/pointer_stepper.sv
`timescale 1ns/1ns
`default_nettype none
`include "alu_defs.svh"

module pointer_stepper (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       load,
    input  wire logic [7:0] load_value,
    input  wire logic       step,
    input  wire logic [1:0] mode,
    // pointer value
    output logic      [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    // RULE_14: mode selects step
    always_comb begin
        value_next = value_reg;
        if (load) begin
            value_next = load_value;
        end else if (step) begin
            if (mode == `PTR_MODE_DEC) begin
                value_next = value_reg - 8'h01;
            end else if (mode == `PTR_MODE_INC) begin
                value_next = value_reg + 8'h01;
            end
        end
    end

    // pointer contents are unknown at power-on and kept by any reset
    always_ff @(posedge clk) begin
        value_reg <= value_next;
    end

    assign value = value_reg;

    property p_step(logic [1:0] m, logic [7:0] delta);
        @(posedge clk) disable iff (!rst_n)
        (step && !load && mode == m) |=> value == $past(value) + delta;
    endproperty

    chk_ptr_increment: assert property (p_step(2'h1, 8'h01)) // RULE_14
        else $error("pointer did not increment");
    chk_ptr_decrement: assert property (p_step(2'h0, 8'hff)) // RULE_14
        else $error("pointer did not decrement");
    chk_ptr_hold: assert property (@(posedge clk) // RULE_14
        disable iff (!rst_n)
        (step && !load && mode[1]) |=> $stable(value))
        else $error("pointer moved in hold mode");

endmodule

`default_nettype wire

// ### rtl/alu_status_flags.sv
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "alu_defs.svh"

// ----------------------------------------------------------------
// Overview of operation
// RULE_01: ALU performs arithmetic and logic operations with one or two operands.
// RULE_02: single-operand operations read and write working register or file register.
// RULE_03: two-operand operations use working register plus file or 8-bit immediate.
// RULE_04: flag-affecting operation into flags register keeps computed flags, not data.
// RULE_05: clearing flags register gives 0000u1uu.
// RULE_06: software alters flags only by bit, swap or move operations.
// RULE_07: carry and half-carry act as inverted borrow during subtraction.
// RULE_08: signed range error set when result leaves -128..+127.
// RULE_09: flags register holds status flags and both pointer update modes.
// RULE_10: product low/high bytes at 18h/19h hold 16-bit multiply; optional.
// RULE_11: product bytes unknown at power-on, kept through other resets.
// RULE_12: unimplemented bits and registers read as zero.
// RULE_13: flags layout modes 7:6 and 5:4, then 3..0; power-on upper 1111.
// RULE_14: mode 00 decrements pointer, 01 increments, 1x holds.
// RULE_15: half-carry from bit 3, carry from bit 7 on addition.
// RULE_16: rotate through carry loads carry with bit shifted out.
// RULE_17: range error is carry-in xor carry-out of bit 7; zero when all clear.
// RULE_18: subtraction adds two's complement through the shared adder.
// ----------------------------------------------------------------
module alu_status_flags #(
    parameter bit HAS_MULTIPLIER = 1'b1
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external reset pin or watchdog reset, synchronous
    input  wire logic        warm_reset
);
    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic             setup;
    logic             wr;
    logic             in_range;
    logic [7:0]       index;
    logic             exec;
    alu_pkg::op_t     op;
    alu_pkg::src_t    src;
    alu_pkg::dst_t    dst;
    logic [7:0]       imm;

    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite;
    assign in_range = (paddr[11:10] == 2'h0);
    assign index    = paddr[9:2];
    assign exec     = wr & in_range & (index == `IDX_OP_CMD);
    assign op       = alu_pkg::op_t'(pwdata[`CMD_OP_LSB +: 4]);
    assign src      = alu_pkg::src_t'(pwdata[`CMD_SRC_LSB +: 2]);
    assign dst      = alu_pkg::dst_t'(pwdata[`CMD_DST_LSB +: 2]);
    assign imm      = pwdata[`CMD_IMM_LSB +: 8];

    function automatic logic reg_write(input logic [7:0] idx);
        return wr && in_range && (index == idx);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0]  flags_hi_reg;
    logic [3:0]  flags_lo_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  work_reg;
    logic [7:0]  work_next;
    logic [7:0]  file_reg;
    logic [7:0]  file_next;
    logic [15:0] prod_reg;
    logic [15:0] prod_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic [7:0]  ptr0;
    logic [7:0]  ptr1;

    // RULE_09: one register, status plus modes
    assign flags_reg = {flags_hi_reg, flags_lo_reg};

    // ----------------------------------------------------------------
    // operand selection and adder
    // ----------------------------------------------------------------
    logic [7:0] opnd;
    logic [7:0] result;
    logic [3:0] calc;
    logic [3:0] affect;
    logic       store;

    alu_add_if add_bus (.clk(pclk), .rst_n(presetn));

    alu_adder8 u_adder (.add(add_bus.adder));

    // RULE_02: file or working register operand
    // RULE_03: second operand is file or immediate
    always_comb begin
        case (src)
            alu_pkg::SRC_FILE: opnd = file_reg;
            alu_pkg::SRC_IMM:  opnd = imm;
            default:           opnd = work_reg;
        endcase
    end

    // RULE_18: subtract as add of complement
    always_comb begin
        add_bus.a   = opnd;
        add_bus.b   = work_reg;
        add_bus.cin = 1'b0;
        case (op)
            alu_pkg::OP_ADDC: add_bus.cin = flags_reg[`FLG_CARRY];
            alu_pkg::OP_SUB: begin
                add_bus.b   = ~work_reg;
                add_bus.cin = 1'b1;
            end
            alu_pkg::OP_INC: begin
                add_bus.b   = 8'h00;
                add_bus.cin = 1'b1;
            end
            alu_pkg::OP_DEC: add_bus.b = 8'hff;
            default: ;
        endcase
    end

    // ----------------------------------------------------------------
    // result and flag computation
    // ----------------------------------------------------------------
    // RULE_01: arithmetic and logic operations
    always_comb begin
        result = opnd;
        affect = 4'h0;
        store  = 1'b1;
        case (op)
            alu_pkg::OP_ADD, alu_pkg::OP_ADDC, alu_pkg::OP_SUB,
            alu_pkg::OP_INC, alu_pkg::OP_DEC: begin
                result = add_bus.sum;
                affect = 4'hf;
            end
            alu_pkg::OP_AND: begin
                result = work_reg & opnd;
                affect = 4'h4;
            end
            alu_pkg::OP_OR: begin
                result = work_reg | opnd;
                affect = 4'h4;
            end
            alu_pkg::OP_XOR: begin
                result = work_reg ^ opnd;
                affect = 4'h4;
            end
            alu_pkg::OP_CLEAR: begin
                result = 8'h00;
                affect = 4'h4;
            end
            alu_pkg::OP_COMP: begin
                result = ~opnd;
                affect = 4'h4;
            end
            alu_pkg::OP_RRC: begin
                result = {flags_reg[`FLG_CARRY], opnd[7:1]};
                affect = 4'h1;
            end
            alu_pkg::OP_RLC: begin
                result = {opnd[6:0], flags_reg[`FLG_CARRY]};
                affect = 4'h1;
            end
            alu_pkg::OP_SWAP: result = {opnd[3:0], opnd[7:4]};
            alu_pkg::OP_BIT:
                result[pwdata[`CMD_BIT_LSB +: 3]] = pwdata[`CMD_BITSET];
            alu_pkg::OP_MUL: store = 1'b0;
            default: ;
        endcase
    end

    // RULE_07: borrow is the inverted adder carry
    // RULE_15: half-carry and carry from adder
    // RULE_16: carry takes the bit rotated out
    // RULE_17: zero and range error
    always_comb begin
        calc              = {add_bus.ovf, 1'b0, add_bus.half, add_bus.cout};
        calc[`FLG_ZERO]   = (result == 8'h00);
        if (op == alu_pkg::OP_RRC) begin
            calc[`FLG_CARRY] = opnd[0];
        end else if (op == alu_pkg::OP_RLC) begin
            calc[`FLG_CARRY] = opnd[7];
        end
    end

    // ----------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        work_next  = work_reg;
        file_next  = file_reg;
        prod_next  = prod_reg;
        if (reg_write(`IDX_FLAGS)) begin
            flags_next = pwdata[7:0];
        end
        if (reg_write(`IDX_WORK)) begin
            work_next = pwdata[7:0];
        end
        if (reg_write(`IDX_FILE_OPND)) begin
            file_next = pwdata[7:0];
        end
        if (HAS_MULTIPLIER && reg_write(`IDX_PROD_LO)) begin
            prod_next[7:0] = pwdata[7:0];
        end
        if (HAS_MULTIPLIER && reg_write(`IDX_PROD_HI)) begin
            prod_next[15:8] = pwdata[7:0];
        end
        if (exec) begin
            flags_next[3:0] = (flags_reg[3:0] & ~affect) | (calc & affect);
            if (store && dst == alu_pkg::DST_WORK) begin
                work_next = result;
            end
            if (store && dst == alu_pkg::DST_FILE) begin
                file_next = result;
            end
            // RULE_04: status bits ignore the data write
            // RULE_05: clear keeps range error unchanged
            if (store && dst == alu_pkg::DST_FLAGS) begin
                flags_next[7:4] = result[7:4];
                if (affect == 4'h0) begin
                    flags_next[3:0] = result[3:0];
                end
            end
            // RULE_10: 8 x 8 product into both bytes
            if (HAS_MULTIPLIER && op == alu_pkg::OP_MUL) begin
                prod_next = {8'h00, work_reg} * {8'h00, opnd};
            end
        end
        // RULE_13: warm reset restores the mode nibble only
        if (warm_reset) begin
            flags_next[7:4] = `FLAGS_HI_RST;
        end
    end

    // RULE_13: power-on sets the mode nibble
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_hi_reg <= `FLAGS_HI_RST;
        end else begin
            flags_hi_reg <= flags_next[7:4];
        end
    end

    // RULE_11: no reset, unknown at power-on
    // status, working, file and product values are data, not control
    always_ff @(posedge pclk) begin
        flags_lo_reg <= flags_next[3:0];
        work_reg     <= work_next;
        file_reg     <= file_next;
        prod_reg     <= prod_next;
    end

    // ----------------------------------------------------------------
    // indirect pointers
    // ----------------------------------------------------------------
    logic step_write;

    assign step_write = reg_write(`IDX_PTR_STEP);

    pointer_stepper u_ptr0 (
        .clk        (pclk),
        .rst_n      (presetn),
        .load       (reg_write(`IDX_PTR0)),
        .load_value (pwdata[7:0]),
        .step       (step_write & pwdata[0]),
        .mode       (flags_reg[`FLG_P0_LSB +: 2]),
        .value      (ptr0)
    );

    pointer_stepper u_ptr1 (
        .clk        (pclk),
        .rst_n      (presetn),
        .load       (reg_write(`IDX_PTR1)),
        .load_value (pwdata[7:0]),
        .step       (step_write & pwdata[1]),
        .mode       (flags_reg[`FLG_P1_LSB +: 2]),
        .value      (ptr1)
    );

    // ----------------------------------------------------------------
    // read path, captured in the setup cycle
    // ----------------------------------------------------------------
    // RULE_12: upper bits and write-only registers read zero
    always_comb begin
        prdata_next  = prdata_reg;
        pslverr_next = pslverr_reg;
        if (setup) begin
            prdata_next  = 32'h0000_0000;
            pslverr_next = ~in_range;
            if (in_range) begin
                case (index)
                    `IDX_PTR0:      prdata_next[7:0] = ptr0;
                    `IDX_FLAGS:     prdata_next[7:0] = flags_reg;
                    `IDX_PTR1:      prdata_next[7:0] = ptr1;
                    `IDX_WORK:      prdata_next[7:0] = work_reg;
                    `IDX_PROD_LO:
                        prdata_next[7:0] = HAS_MULTIPLIER ? prod_reg[7:0]
                                                          : 8'h00;
                    `IDX_PROD_HI:
                        prdata_next[7:0] = HAS_MULTIPLIER ? prod_reg[15:8]
                                                          : 8'h00;
                    `IDX_FILE_OPND: prdata_next[7:0] = file_reg;
                    `IDX_OP_CMD, `IDX_PTR_STEP: ;
                    default:        pslverr_next = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg & psel & penable;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       plain_exec;
    logic [8:0] signed_sum;

    assign plain_exec = exec && !warm_reset && dst != alu_pkg::DST_FLAGS;
    assign signed_sum = {opnd[7], opnd} + {work_reg[7], work_reg};

    sequence s_exec(alu_pkg::op_t o);
        plain_exec && op == o;
    endsequence

    sequence s_unmapped_read;
        setup && !pwrite && (!in_range || index > `IDX_PTR_STEP);
    endsequence

    chk_clear_flags: assert property ( // RULE_05
        exec && !warm_reset && op == alu_pkg::OP_CLEAR
            && dst == alu_pkg::DST_FLAGS
        |=> flags_reg[7:4] == 4'h0 && flags_reg[`FLG_ZERO]
            && flags_reg[1:0] == $past(flags_reg[1:0])
            && flags_reg[3] == $past(flags_reg[3]))
        else $error("cleared flags register not 0000u1uu");
    chk_flags_dest_guard: assert property ( // RULE_04
        exec && !warm_reset && op == alu_pkg::OP_SUB
            && dst == alu_pkg::DST_FLAGS
        |=> flags_reg[`FLG_CARRY] == $past(add_bus.cout)
            && flags_reg[7:4] == $past(add_bus.sum[7:4]))
        else $error("flags destination took written carry");
    chk_sub_borrow: assert property ( // RULE_07
        s_exec(alu_pkg::OP_SUB)
        |=> flags_reg[`FLG_CARRY] == ($past(opnd) >= $past(work_reg))
            && flags_reg[`FLG_SPILL]
               == ($past(opnd[3:0]) >= $past(work_reg[3:0])))
        else $error("borrow flags wrong after subtraction");
    chk_signed_range: assert property ( // RULE_08
        s_exec(alu_pkg::OP_ADD)
        |=> flags_reg[`FLG_RANGE] == ($past(signed_sum[8])
                                      ^ $past(signed_sum[7])))
        else $error("signed range error flag wrong");
    chk_add_carries: assert property ( // RULE_15
        s_exec(alu_pkg::OP_ADD) ##1 !warm_reset
        |-> flags_reg[`FLG_CARRY]
                == ({1'b0, $past(opnd)} + {1'b0, $past(work_reg)} > 9'h0ff)
            && flags_reg[`FLG_SPILL]
                == ({1'b0, $past(opnd[3:0])}
                    + {1'b0, $past(work_reg[3:0])} > 5'h0f))
        else $error("add carry or half-carry wrong");
    chk_rotate_carry: assert property ( // RULE_16
        s_exec(alu_pkg::OP_RLC)
        |=> flags_reg[`FLG_CARRY] == $past(opnd[7]))
        else $error("rotate did not load shifted-out bit");
    chk_zero_flag: assert property ( // RULE_17
        s_exec(alu_pkg::OP_XOR)
        |=> flags_reg[`FLG_ZERO] == ($past(opnd) == $past(work_reg)))
        else $error("zero flag wrong after logic operation");
    chk_product_value: assert property ( // RULE_10
        HAS_MULTIPLIER && exec && op == alu_pkg::OP_MUL
        |=> prod_reg == {8'h00, $past(work_reg)} * {8'h00, $past(opnd)})
        else $error("product registers hold wrong value");
    chk_product_keep: assert property ( // RULE_11
        warm_reset && !wr |=> $stable(prod_reg) && $stable(work_reg))
        else $error("warm reset disturbed product or working register");
    chk_warm_modes: assert property ( // RULE_13
        warm_reset && !wr
        |=> flags_reg[7:4] == 4'hf && $stable(flags_reg[3:0]))
        else $error("warm reset left wrong flags pattern");
    chk_unmapped_zero: assert property ( // RULE_12
        s_unmapped_read ##1 (psel && penable)
        |-> prdata == 32'h0000_0000 && pslverr)
        else $error("unmapped read not zero with error");

endmodule

`default_nettype wire

// ### testbench/decoder_model.sv
`timescale 1ns/1ns
`default_nettype none

module decoder_model (
    // apb master side
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    logic err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    // ----
    // one transfer; waits on pready, no fixed wait count assumed
    // ----
    task automatic xfer(input logic w, input logic [7:0] i,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data goes stale-inverted so nothing leans on it
        pwdata <= ~d;
    endtask
endmodule

`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        warm_reset = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          fails = 0;
    int          checked = 0;
    always #50 pclk = ~pclk;
    alu_status_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .warm_reset(warm_reset));
    decoder_model i_dec (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    // ----
    // helpers
    // ----
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] q;
        i_dec.xfer(1'b1, i, d, q);
    endtask
    task automatic rd(input string n, input logic [7:0] i, e);
        logic [31:0] q;
        i_dec.xfer(1'b0, i, 32'h0, q);
        chk(n, q, {24'h0, e});
    endtask
    task automatic op(input logic [3:0] o, input logic [1:0] s, d,
                      input logic [7:0] m);
        wr(8'h20, {16'h0, m, d, s, o});
    endtask
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        logic [31:0] q;
        i_dec.xfer(1'b0, 8'h04, 32'h0, q);
        chk("flags_hi", q & 32'hf0, 32'hf0);
        chk("flags_err", {31'h0, i_dec.err}, 32'h0);
        rd("unmapped", 8'h30, 8'h00);
        chk("unmapped_err", {31'h0, i_dec.err}, 32'h1);
        $display("t_reset done");
    endtask
    task automatic t_arith;
        wr(8'h04, 32'h00);
        wr(8'h0a, 32'h88);
        op(alu_pkg::OP_ADD, 2'h2, 2'h3, 8'h88);
        rd("add_flags", 8'h04, 8'h0b);
        wr(8'h0a, 32'h01);
        op(alu_pkg::OP_SUB, 2'h2, 2'h0, 8'h01);
        rd("sub_flags", 8'h04, 8'h07);
        rd("sub_work", 8'h0a, 8'h00);
        wr(8'h21, 32'hff);
        op(alu_pkg::OP_INC, 2'h1, 2'h1, 8'h00);
        rd("inc_file", 8'h21, 8'h00);
        $display("t_arith done");
    endtask
    task automatic t_flags;
        wr(8'h04, 32'h08);
        op(alu_pkg::OP_CLEAR, 2'h0, 2'h2, 8'h00);
        rd("clr_flags", 8'h04, 8'h0c);
        wr(8'h0a, 32'h01);
        op(alu_pkg::OP_RRC, 2'h0, 2'h0, 8'h00);
        rd("rrc_work", 8'h0a, 8'h00);
        rd("rrc_flags", 8'h04, 8'h0d);
        $display("t_flags done");
    endtask
    task automatic t_mul;
        wr(8'h0a, 32'h12);
        op(alu_pkg::OP_MUL, 2'h2, 2'h3, 8'h34);
        @(posedge pclk);
        warm_reset <= 1'b1;
        @(posedge pclk);
        warm_reset <= 1'b0;
        rd("prod_lo", 8'h18, 8'ha8);
        rd("prod_hi", 8'h19, 8'h03);
        rd("warm_flags", 8'h04, 8'hfd);
        $display("t_mul done");
    endtask
    task automatic t_ptr;
        wr(8'h04, 32'h10);
        wr(8'h01, 32'h10);
        wr(8'h09, 32'h10);
        wr(8'h22, 32'h03);
        wr(8'h04, 32'ha0);
        wr(8'h22, 32'h03);
        rd("ptr0", 8'h01, 8'h11);
        rd("ptr1", 8'h09, 8'h0f);
        $display("t_ptr done");
    endtask
    task automatic t_logic;
        wr(8'h04, 32'h00);
        wr(8'h0a, 32'h5a);
        op(alu_pkg::OP_XOR, 2'h2, 2'h0, 8'h5a);
        rd("xor_flags", 8'h04, 8'h04);
        op(alu_pkg::OP_RLC, 2'h2, 2'h0, 8'h81);
        op(alu_pkg::OP_ADDC, 2'h2, 2'h0, 8'h0f);
        rd("addc_work", 8'h0a, 8'h12);
        op(alu_pkg::OP_SUB, 2'h2, 2'h2, 8'h01);
        rd("sub_to_flags", 8'h04, 8'he0);
        op(alu_pkg::OP_BIT, 2'h0, 2'h0, 8'h08);
        op(alu_pkg::OP_SWAP, 2'h0, 2'h1, 8'h00);
        op(alu_pkg::OP_AND, 2'h2, 2'h0, 8'h0f);
        op(alu_pkg::OP_OR, 2'h2, 2'h0, 8'h30);
        rd("logic_work", 8'h0a, 8'h33);
        op(alu_pkg::OP_COMP, 2'h1, 2'h1, 8'h00);
        op(alu_pkg::OP_DEC, 2'h1, 2'h1, 8'h00);
        op(alu_pkg::OP_MOVE, 2'h2, 2'h0, 8'h00);
        rd("dec_file", 8'h21, 8'hcd);
        rd("move_flags", 8'h04, 8'he3);
        $display("t_logic done");
    endtask
    // under two hundred cycles expected; the 5000-cycle limit is over twenty times that
    initial begin
        #500000;
        fails++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_arith();
        t_flags();
        t_mul();
        t_ptr();
        t_logic();
        test_done();
    end
endmodule

`default_nettype wire
